// file: hw/tpg_pkg.sv
// Shared constants, types and configuration layout of the pattern generator
package tpg_pkg;
  localparam int LEN_W          = 23;
  localparam int ADDR_W         = 22;
  localparam int WORD_ADDR_W    = 17;
  localparam int MEM_WORD_W     = 32;
  localparam int BIT_SEL_W      = 5;
  localparam int LFSR_W         = 31;
  localparam int HIST_W         = 32;
  localparam int ALT_WORD_W     = 16;
  localparam int STORE_SHIFT    = 13;
  localparam int USER_FINE_LOG2 = 15;
  localparam int ALT_FINE_LOG2  = 14;
  localparam int INS_LOG2       = 7;
  localparam int RATE_STEPS     = 7;
  localparam int ERR_PEND_W     = 3;

  localparam logic [LEN_W-1:0]  USER_MAX_LEN = 23'h400000;
  localparam logic [LEN_W-1:0]  ALT_MAX_LEN  = 23'h200000;
  localparam logic [ADDR_W-1:0] ALT_B_BASE   = 22'h200000;
  localparam logic [2:0]        LARGE_STORE  = 3'h4;
  localparam logic [3:0]        WORD_LAST    = 4'hf;
  localparam logic [3:0]        DIV_LAST     = 4'hf;
  localparam logic [7:0]        INS_FULL     = 8'h80;

  // Derived pattern lengths
  localparam logic [LEN_W-1:0] DLEN_8192 = 23'h002000;
  localparam logic [LEN_W-1:0] DLEN_2048 = 23'h000800;
  localparam logic [LEN_W-1:0] DLEN_1024 = 23'h000400;
  localparam logic [LEN_W-1:0] DLEN_128  = 23'h000080;

  // Feedback tap masks, bit k stands for power k+1
  localparam logic [LFSR_W-1:0] TAPS31 = 31'h48000000;
  localparam logic [LFSR_W-1:0] TAPS23 = 31'h00420000;
  localparam logic [LFSR_W-1:0] TAPS15 = 31'h00006000;
  localparam logic [LFSR_W-1:0] TAPS13 = 31'h00001b00;
  localparam logic [LFSR_W-1:0] TAPS11 = 31'h00000500;
  localparam logic [LFSR_W-1:0] TAPS10 = 31'h00000240;
  localparam logic [LFSR_W-1:0] TAPS7  = 31'h00000060;

  typedef enum logic [2:0] {
    PAT_PRBS, PAT_ZEROSUB, PAT_DENSITY, PAT_USER, PAT_WORDS, PAT_ALT
  } patSel_t;
  typedef enum logic [2:0] {PRBS31, PRBS23, PRBS15, PRBS10, PRBS7} prbs_t;
  typedef enum logic [1:0] {DER8192, DER2048, DER1024, DER128} derived_t;
  typedef enum logic [2:0] {DEN1_8, DEN1_4, DEN1_2, DEN3_4, DEN7_8} density_t;

  typedef struct packed {
    logic [4:0]        order;
    logic [LFSR_W-1:0] taps;
  } lfsrDef_t;

  typedef struct packed {
    patSel_t                mode;
    prbs_t                  prbs;
    derived_t               derived;
    density_t               density;
    logic [LEN_W-1:0]       zsRun;
    logic [LEN_W-1:0]       userLen;
    logic [2:0]             storeSel;
    logic [LEN_W-1:0]       altLen;
    logic                   altRearSrc;
    logic                   altOnce;
    logic                   altUserB;
    logic                   altSyncAux;
    logic                   syncDiv;
    logic [LEN_W-1:0]       syncPos;
    logic [ALT_WORD_W-1:0]  word0;
    logic [ALT_WORD_W-1:0]  word1;
    logic [HIST_W-1:0]      trigPat;
    logic [HIST_W-1:0]      trigMask;
    logic                   errRateOn;
    logic [2:0]             errRate;
  } cfg_t;

  typedef struct packed {
    logic data;
    logic sync;
  } sample_t;
endpackage

// file: hw/sample_fifo.sv
// Small synchronous FIFO between pattern generation and the output stage
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,      // System clock
  input  wire logic             rstN,     // Synchronised reset, active low
  input  wire logic             en,       // Clock enable
  input  wire logic [WIDTH-1:0] inData,   // Write data
  input  wire logic             inValid,  // Write request
  output logic                  inReady,  // Space available
  output logic [WIDTH-1:0]      outData,  // Head word
  output logic                  outValid, // Head word present
  input  wire logic             outReady  // Reader takes head word
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
      $error("sample_fifo: DEPTH must be a power of two >= 2");
    end
  endgenerate

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0]      wrPtr_q;
  logic [AW:0]      rdPtr_q;
  logic             push;
  logic             pop;

  assign inReady  = (wrPtr_q ^ rdPtr_q) != {1'b1, {AW{1'b0}}};
  assign outValid = wrPtr_q != rdPtr_q;
  assign outData  = store[rdPtr_q[AW-1:0]];
  assign push     = en && inValid && inReady;
  assign pop      = en && outReady && outValid;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      store[wrPtr_q[AW-1:0]] <= inData;
    end
  end
endmodule // sample_fifo

// file: hw/test_pattern_generator.sv
// Serial test-pattern generator core: sequences, stores, alternation, errors, sync
`timescale 1ns/1ps
// Functional notes
// - Inverted PRBS 31/23/15/10/7 with given taps
// - Derived 8192/2048/1024/128-bit patterns from PRBS
// - Zero substitution, following bit forced one
// - Mark density 1/8 to 7/8 selectable
// - User patterns 1 to 4194304 bits, looping
// - User length step doubles above 32 kbits
// - Four 8192-bit stores plus large stores
// - Two 16-bit words, switch at word end
// - A/B switch only at pattern end, hitless
// - Single insertion repeats B to 128 multiple
// - A and B share length, up to 2 Mbits
// - Alternate length step doubles above 16 kbits
// - Single errors or fixed rate 1e9..1e3
// - One inverted bit per inject rising edge
// - PRBS sync: pattern pulse or clock/32
// - Sync when trigger word matches output
// - Word sync: retimed control input or clock/32
// - Derived and user sync at programmable bit
// - Alternate sync: control-aligned or one pulse per pattern
// - Flag missing or weak input clock
// - Rear source makes control input pick A/B
// - Level mode: low gives A, high B
// - Rising control edge starts one insertion
// - Word select low first, high/absent second
// - Otherwise low control input forces data zero
module test_pattern_generator #(
  parameter int MEM_BITS = 4194304,
  parameter int ERR_BASE = 1000,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic                  sys_clk,      // 100 MHz bit clock
  input  wire logic                  reset_n,      // Async reset, active low
  input  wire logic                  clkEn,        // Freezes all state except the reset synchroniser when low
  input  wire tpg_pkg::cfg_t         cfg,          // Pattern configuration
  input  wire logic                  auxIn,        // Rear control input level
  input  wire logic                  auxPresent,   // Rear control input driven
  input  wire logic                  errInject,    // External error inject
  input  wire logic                  singleErr,    // One-cycle single error request
  input  wire logic                  insertReq,    // One-cycle insertion request
  input  wire logic                  clockSense,   // Clock level detector, high when good
  input  wire logic                  memWe,        // Pattern memory write
  input  wire logic [16:0]           memAddr,      // Pattern memory word address
  input  wire logic [31:0]           memData,      // Pattern memory word, bit 0 first
  input  wire logic                  outReady,     // Serialiser takes a bit
  output logic                       dataOut,      // Serial data bit
  output logic                       syncOut,      // Sync pulse output
  output logic                       outValid,     // Bit on dataOut is new
  output logic                       clockMissing  // Input clock missing or weak
);
  localparam int MEM_WORDS = MEM_BITS / tpg_pkg::MEM_WORD_W;

  generate
    if (MEM_BITS != 2 ** tpg_pkg::ADDR_W || ERR_BASE < 1 || FIFO_DEPTH < 2) begin : g_chk
      $error("test_pattern_generator: unsupported parameter values");
    end
  endgenerate

  typedef struct packed {
    logic [tpg_pkg::LFSR_W-1:0]     lfsr;
    logic [tpg_pkg::LEN_W-1:0]      pos;
    logic [3:0]                     wordPos;
    logic                           wordSel;
    logic                           curB;
    logic [7:0]                     insLeft;
    logic                           insArmed;
    logic                           auxPrev;
    logic                           injPrev;
    logic [tpg_pkg::ERR_PEND_W-1:0] errPend;
    logic [31:0]                    rateCnt;
    logic [tpg_pkg::HIST_W-1:0]     hist;
    logic [3:0]                     divCnt;
    logic                           divClk;
    logic                           auxSync;
    logic                           dataOut;
    logic                           syncOut;
    logic                           outValid;
    logic                           clockMissing;
  } core_t;

  function automatic tpg_pkg::lfsrDef_t lfsrDef(input tpg_pkg::cfg_t c);
    tpg_pkg::lfsrDef_t d;
    d = '{order: 5'd31, taps: tpg_pkg::TAPS31};
    if (c.mode == tpg_pkg::PAT_PRBS) begin
      unique case (c.prbs)
        tpg_pkg::PRBS31: d = '{order: 5'd31, taps: tpg_pkg::TAPS31};
        tpg_pkg::PRBS23: d = '{order: 5'd23, taps: tpg_pkg::TAPS23};
        tpg_pkg::PRBS15: d = '{order: 5'd15, taps: tpg_pkg::TAPS15};
        tpg_pkg::PRBS10: d = '{order: 5'd10, taps: tpg_pkg::TAPS10};
        tpg_pkg::PRBS7:  d = '{order: 5'd7,  taps: tpg_pkg::TAPS7};
        default:         d = '{order: 5'd31, taps: tpg_pkg::TAPS31};
      endcase
    end else begin
      unique case (c.derived)
        tpg_pkg::DER8192: d = '{order: 5'd13, taps: tpg_pkg::TAPS13};
        tpg_pkg::DER2048: d = '{order: 5'd11, taps: tpg_pkg::TAPS11};
        tpg_pkg::DER1024: d = '{order: 5'd10, taps: tpg_pkg::TAPS10};
        tpg_pkg::DER128:  d = '{order: 5'd7,  taps: tpg_pkg::TAPS7};
      endcase
    end
    return d;
  endfunction

  // Clamp to range and drop bits below the step for this length
  function automatic logic [tpg_pkg::LEN_W-1:0] legalLen(
    input logic [tpg_pkg::LEN_W-1:0] len,
    input int                        fineLog2,
    input logic [tpg_pkg::LEN_W-1:0] maxLen);
    logic [tpg_pkg::LEN_W-1:0] l;
    int                        sh;
    l  = (len > maxLen) ? maxLen : ((len == '0) ? tpg_pkg::LEN_W'(1) : len);
    sh = 0;
    for (int i = 0; i < tpg_pkg::LEN_W; i++) begin
      if (l[i] && i >= fineLog2) begin
        sh = i - fineLog2 + 1;
      end
    end
    return l & ({tpg_pkg::LEN_W{1'b1}} << sh);
  endfunction

  function automatic logic [7:0] insReps(input logic [tpg_pkg::LEN_W-1:0] len);
    logic [7:0] r;
    logic       done;
    r    = tpg_pkg::INS_FULL;
    done = 1'b0;
    for (int i = 0; i < tpg_pkg::INS_LOG2; i++) begin
      if (!done && !len[i]) begin
        r = r >> 1;
      end else begin
        done = 1'b1;
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] ratePeriod(input logic [2:0] sel);
    logic [31:0] p;
    p = 32'(ERR_BASE);
    for (int i = 1; i < tpg_pkg::RATE_STEPS; i++) begin
      if (i <= int'(sel)) begin
        p = 32'(p * 32'd10);
      end
    end
    return p;
  endfunction

  core_t                        q;
  core_t                        n;
  logic                         rstMeta_q;
  logic                         rstSync_q;
  logic [31:0]                  patMem [MEM_WORDS];
  tpg_pkg::lfsrDef_t            def;
  logic [tpg_pkg::LFSR_W-1:0]   msk;
  logic [tpg_pkg::LFSR_W-1:0]   s;
  logic [tpg_pkg::LFSR_W-1:0]   sNext;
  logic [tpg_pkg::LEN_W-1:0]    curLen;
  logic [tpg_pkg::LEN_W-1:0]    uLen;
  logic [tpg_pkg::LEN_W-1:0]    aLen;
  logic [tpg_pkg::ADDR_W-1:0]   rdAddr;
  logic                         memBit;
  logic                         pBit;
  logic                         auxEff;
  logic                         patEnd;
  logic                         bitOut;
  logic                         syncBit;
  logic                         gen;
  logic                         trigRise;
  logic                         rateHit;
  logic                         flip;
  logic [tpg_pkg::ERR_PEND_W:0] pendSum;
  tpg_pkg::sample_t             genSample;
  tpg_pkg::sample_t             fifoOut;
  logic                         fifoValid;
  logic [tpg_pkg::HIST_W-1:0]   histNext;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  // Stores 0..3 are 8192-bit regions, larger selections use the whole array
  always_ff @(posedge sys_clk) begin
    if (clkEn && memWe) begin
      patMem[memAddr] <= memData;
    end
  end

  sample_fifo #(
    .WIDTH ($bits(tpg_pkg::sample_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (sys_clk),
    .rstN     (rstSync_q),
    .en       (clkEn),
    .inData   (genSample),
    .inValid  (1'b1),
    .inReady  (gen),
    .outData  (fifoOut),
    .outValid (fifoValid),
    .outReady (outReady)
  );

  always_comb begin
    n        = q;
    def      = lfsrDef(cfg);
    msk      = tpg_pkg::LFSR_W'((32'h1 << def.order) - 32'h1);
    s        = ((q.lfsr & msk) == '0) ? msk : (q.lfsr & msk);
    sNext    = ((s << 1) | tpg_pkg::LFSR_W'(^(s & def.taps))) & msk;
    pBit     = ~s[def.order - 5'd1];
    uLen     = legalLen(cfg.userLen, tpg_pkg::USER_FINE_LOG2, tpg_pkg::USER_MAX_LEN);
    aLen     = legalLen(cfg.altLen, tpg_pkg::ALT_FINE_LOG2, tpg_pkg::ALT_MAX_LEN);
    // Absent control input reads as high
    auxEff   = auxPresent ? auxIn : 1'b1;
    curLen   = '0;
    rdAddr   = tpg_pkg::ADDR_W'(q.pos);
    unique case (cfg.mode)
      tpg_pkg::PAT_ZEROSUB, tpg_pkg::PAT_DENSITY: begin
        unique case (cfg.derived)
          tpg_pkg::DER8192: curLen = tpg_pkg::DLEN_8192;
          tpg_pkg::DER2048: curLen = tpg_pkg::DLEN_2048;
          tpg_pkg::DER1024: curLen = tpg_pkg::DLEN_1024;
          tpg_pkg::DER128:  curLen = tpg_pkg::DLEN_128;
        endcase
      end
      tpg_pkg::PAT_USER: begin
        curLen = uLen;
        if (cfg.storeSel < tpg_pkg::LARGE_STORE) begin
          rdAddr = tpg_pkg::ADDR_W'({cfg.storeSel, {tpg_pkg::STORE_SHIFT{1'b0}}})
                   + tpg_pkg::ADDR_W'(q.pos);
        end
      end
      tpg_pkg::PAT_ALT: begin
        curLen = aLen;
        rdAddr = (q.curB ? tpg_pkg::ALT_B_BASE : '0) + tpg_pkg::ADDR_W'(q.pos);
      end
      default: curLen = '0;
    endcase
    memBit = patMem[rdAddr[tpg_pkg::ADDR_W-1:tpg_pkg::BIT_SEL_W]]
                   [rdAddr[tpg_pkg::BIT_SEL_W-1:0]];
    patEnd = (q.pos >= curLen - tpg_pkg::LEN_W'(1));

    // Pattern bit; derived patterns pad the 2^n-1 sequence by one zero at the end
    bitOut = pBit;
    unique case (cfg.mode)
      tpg_pkg::PAT_PRBS: bitOut = pBit;
      tpg_pkg::PAT_ZEROSUB: begin
        bitOut = patEnd ? 1'b0 : pBit;
        if (q.pos < cfg.zsRun) begin
          bitOut = 1'b0;
        end else if (q.pos == cfg.zsRun) begin
          bitOut = 1'b1;
        end
      end
      tpg_pkg::PAT_DENSITY: begin
        unique case (cfg.density)
          tpg_pkg::DEN1_8: bitOut = pBit & ~s[def.order-5'd2] & ~s[def.order-5'd3];
          tpg_pkg::DEN1_4: bitOut = pBit & ~s[def.order-5'd2];
          tpg_pkg::DEN1_2: bitOut = pBit;
          tpg_pkg::DEN3_4: bitOut = pBit | ~s[def.order-5'd2];
          tpg_pkg::DEN7_8: bitOut = pBit | ~s[def.order-5'd2] | ~s[def.order-5'd3];
          default:         bitOut = pBit;
        endcase
        if (patEnd) begin
          bitOut = 1'b0;
        end
      end
      tpg_pkg::PAT_USER, tpg_pkg::PAT_ALT: bitOut = memBit;
      tpg_pkg::PAT_WORDS: bitOut = q.wordSel ? cfg.word1[4'd15 - q.wordPos]
                                             : cfg.word0[4'd15 - q.wordPos];
      default: bitOut = pBit;
    endcase
    if (cfg.mode != tpg_pkg::PAT_WORDS && cfg.mode != tpg_pkg::PAT_ALT && !auxEff) begin
      bitOut = 1'b0;
    end

    // Errors queue so coincident requests each invert their own bit
    rateHit = cfg.errRateOn && gen && (q.rateCnt >= ratePeriod(cfg.errRate) - 32'd1);
    pendSum = {1'b0, q.errPend} + (errInject & ~q.injPrev)
              + singleErr + rateHit;
    flip    = gen && (pendSum != '0);
    pendSum = pendSum - flip;
    n.errPend = (pendSum[tpg_pkg::ERR_PEND_W]) ? '1 : pendSum[tpg_pkg::ERR_PEND_W-1:0];
    n.injPrev = errInject;
    bitOut    = bitOut ^ flip;
    if (cfg.errRateOn && gen) begin
      n.rateCnt = rateHit ? '0 : q.rateCnt + 32'd1;
    end

    histNext = {q.hist[tpg_pkg::HIST_W-2:0], bitOut};
    unique case (cfg.mode)
      tpg_pkg::PAT_PRBS: syncBit = cfg.syncDiv ? q.divClk
                         : (cfg.trigMask != '0
                            && ((histNext ^ cfg.trigPat) & cfg.trigMask) == '0);
      tpg_pkg::PAT_WORDS: syncBit = cfg.syncDiv ? q.divClk : q.auxSync;
      tpg_pkg::PAT_ALT: syncBit = cfg.altSyncAux ? q.auxSync
                                                 : (q.pos == '0);
      default: syncBit = (q.pos == cfg.syncPos);
    endcase
    genSample = '{data: bitOut, sync: syncBit};

    // Free-running parts
    n.auxSync = auxEff;
    n.auxPrev = auxEff;
    n.divCnt  = q.divCnt + 4'd1;
    if (q.divCnt == tpg_pkg::DIV_LAST) begin
      n.divClk = ~q.divClk;
    end
    n.clockMissing = ~clockSense;
    trigRise = cfg.altRearSrc ? (auxEff & ~q.auxPrev) : insertReq;
    if (trigRise && cfg.altOnce) begin
      n.insArmed = 1'b1;
    end

    if (gen) begin
      n.hist = histNext;
      if (cfg.mode == tpg_pkg::PAT_PRBS || (!patEnd && (cfg.mode == tpg_pkg::PAT_ZEROSUB
          || cfg.mode == tpg_pkg::PAT_DENSITY))) begin
        n.lfsr = sNext;
      end else begin
        n.lfsr = s;
      end
      n.pos     = patEnd ? '0 : q.pos + tpg_pkg::LEN_W'(1);
      n.wordPos = q.wordPos + 4'd1;
      if (q.wordPos == tpg_pkg::WORD_LAST) begin
        n.wordSel = auxEff;
      end
      if (cfg.mode == tpg_pkg::PAT_ALT && patEnd) begin
        if (!cfg.altOnce) begin
          n.curB = cfg.altRearSrc ? auxEff : cfg.altUserB;
        end else if (q.insLeft > 8'd1) begin
          n.curB    = 1'b1;
          n.insLeft = q.insLeft - 8'd1;
        end else if (q.insArmed) begin
          n.curB     = 1'b1;
          n.insLeft  = insReps(aLen);
          n.insArmed = trigRise;
        end else begin
          n.curB    = 1'b0;
          n.insLeft = '0;
        end
      end
    end

    n.outValid = fifoValid && outReady;
    if (fifoValid && outReady) begin
      n.dataOut = fifoOut.data;
      n.syncOut = fifoOut.sync;
    end
  end

  always_ff @(posedge sys_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      q      <= '0;
      q.lfsr <= '1;
      q.auxPrev <= 1'b1;
    end else if (clkEn) begin
      q <= n;
    end
  end

  assign dataOut      = q.dataOut;
  assign syncOut      = q.syncOut;
  assign outValid     = q.outValid;
  assign clockMissing = q.clockMissing;
endmodule // test_pattern_generator

// file: tb/tpg_checker_sva.sv
// Port assertions of the pattern generator
`timescale 1ns/1ps
module tpg_checker (
  input wire logic          sys_clk,     // Bit clock
  input wire logic          reset_n,     // Async reset
  input wire tpg_pkg::cfg_t cfg,         // Configuration
  input wire logic          auxIn,       // Control level
  input wire logic          auxPresent,  // Control driven
  input wire logic          clockSense,  // Clock detector
  input wire logic          outReady,    // Drain ready
  input wire logic          dataOut,     // Serial bit
  input wire logic          syncOut,     // Sync output
  input wire logic          outValid,    // New bit
  input wire logic          clockMissing // Clock flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic       divMode, inhMode, syncPrev_q, seen_q;
  logic [5:0] runLen_q, inhCnt_q, stall_q, ready_q;
  assign divMode = cfg.mode == tpg_pkg::PAT_PRBS && cfg.syncDiv;
  assign inhMode = cfg.mode inside {tpg_pkg::PAT_PRBS, tpg_pkg::PAT_USER}
                   && auxPresent && !auxIn;
  // Runs only trusted once the queue holds bits of an unbroken stream
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      {runLen_q, inhCnt_q, stall_q, ready_q, syncPrev_q, seen_q} <= '0;
    end else begin
      stall_q  <= outReady ? 6'h00 : stall_q + {5'h00, stall_q != 6'h3f};
      ready_q  <= !outReady ? 6'h00 : ready_q + {5'h00, ready_q != 6'h3f};
      inhCnt_q <= !inhMode ? 6'h00 : inhCnt_q + {5'h00, outValid && inhCnt_q != 6'h3f};
      if (outValid) begin
        syncPrev_q <= syncOut;
        runLen_q   <= syncOut != syncPrev_q ? 6'h01 : runLen_q + 6'h01;
        seen_q     <= divMode && outReady
                      && (seen_q || (syncOut != syncPrev_q && ready_q > 6'h14));
      end else if (!divMode || !outReady) begin
        seen_q <= 1'h0;
      end
    end
  end
  a_reset_quiet: assert property ($rose(reset_n) |-> !outValid [*3])
    else $error("bit valid too soon after reset");
  a_hold_bits: assert property (!outValid |-> $stable(dataOut) && $stable(syncOut))
    else $error("output moved without a new bit");
  a_stream_on: assert property (outValid && outReady |=> outValid)
    else $error("gap in continuous stream");
  a_resume_fill: assert property (outReady && stall_q > 6'h0a |-> ##[1:3] outValid)
    else $error("no bit after long stall");
  a_clock_flag: assert property (!clockSense [*2] |-> clockMissing)
    else $error("missing clock not flagged");
  a_div_period: assert property (divMode && seen_q && outValid && syncOut != syncPrev_q
    |-> runLen_q == 6'h10)
    else $error("divided sync half period wrong");
  a_div_bound: assert property (divMode && seen_q |-> runLen_q <= 6'h10)
    else $error("divided sync stuck");
  a_inhibit_zero: assert property (outValid && inhCnt_q > 6'h0b |-> !dataOut)
    else $error("data not held low");
  c_div_toggle: cover property (divMode && seen_q && outValid && syncOut != syncPrev_q);
  c_inhibit: cover property (outValid && inhCnt_q > 6'h0b);
  c_resume: cover property (outReady && stall_q > 6'h0a);
endmodule // tpg_checker

bind test_pattern_generator tpg_checker u_chk (.sys_clk, .reset_n, .cfg, .auxIn,
  .auxPresent, .clockSense, .outReady, .dataOut, .syncOut, .outValid, .clockMissing);

// file: tb/serial_sink.sv
// Serial receiver model on the far side of the data output
`timescale 1ns/1ps
module serial_sink (
  input  wire logic clk,     // Bit clock
  input  wire logic slow,    // Take one bit in four
  input  wire logic hold,    // Refuse bits altogether
  output logic      outReady // Ready for a bit
);
  logic [1:0] phase_q = 2'h0;
  initial outReady = 1'h1;
  // Moves on the falling edge, clear of the generator's sampling edge
  always @(negedge clk) begin
    phase_q  <= phase_q + 2'h1;
    outReady <= !hold && (!slow || phase_q == 2'h0);
  end
endmodule // serial_sink

// file: tb/test_pattern_generator_tb_top.sv
// Self-checking bench of the test pattern generator
`timescale 1ns/1ps
module test_pattern_generator_tb_top;
  logic          sys_clk = 1'h0, reset_n = 1'h0, clkEn = 1'h1, auxIn = 1'h0;
  logic          auxPresent = 1'h0, errInject = 1'h0, singleErr = 1'h0, insertReq = 1'h0;
  logic          clockSense = 1'h1, memWe = 1'h0, slow = 1'h0, hold = 1'h0;
  logic [16:0]   memAddr = '0;
  logic [31:0]   memData = '0;
  logic [31:0]   v;
  tpg_pkg::cfg_t cfg = '0;
  logic          outReady, dataOut, syncOut, outValid, clockMissing;
  logic          bits [0:511];
  logic          sy [0:511];
  int            fail_count = 0;
  int            checked = 0;
  int            ord [5] = '{31, 23, 15, 10, 7};
  int            tap [5] = '{28, 18, 14, 7, 6};

  always #5 sys_clk = ~sys_clk;

  test_pattern_generator #(.ERR_BASE(10)) DUT (.sys_clk, .reset_n, .clkEn, .cfg, .auxIn,
    .auxPresent, .errInject, .singleErr, .insertReq, .clockSense, .memWe, .memAddr,
    .memData, .outReady, .dataOut, .syncOut, .outValid, .clockMissing);
  serial_sink SINK (.clk(sys_clk), .slow, .hold, .outReady);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Each bit is taken in the one cycle its valid flag shows
  task automatic grab(input int n);
    for (int i = 0; i < n; i++) begin
      do @(negedge sys_clk); while (outValid !== 1'h1);
      bits[i] = dataOut;
      sy[i] = syncOut;
    end
  endtask

  // Inverted sequence: each bit xor its two tap bits is always one
  function automatic int viol(input int a, input int b, input int n);
    int e = 0;
    for (int i = a; i < n; i++)
      e += ((bits[i] ^ bits[i-b] ^ bits[i-a]) !== 1'h1);
    return e;
  endfunction

  function automatic int sum(input logic s, input int a, input int n);
    int e = 0;
    for (int i = a; i < a + n; i++)
      e += s ? sy[i] : bits[i];
    return e;
  endfunction

  function automatic logic rotHit(input logic [31:0] x, input logic [31:0] w, input int n);
    logic [31:0] m;
    rotHit = 1'h0;
    m = (n == 32) ? 32'hffffffff : (32'h1 << n) - 32'h1;
    for (int k = 0; k < n; k++)
      if ((x & m) == (((w << k) | (w >> (n - k))) & m)) rotHit = 1'h1;
  endfunction

  task automatic wr(input logic [16:0] a, input logic [31:0] d);
    memAddr = a;
    memData = d;
    memWe = 1'h1;
    @(negedge sys_clk);
    memWe = 1'h0;
    @(negedge sys_clk);
  endtask

  task automatic errRun(input logic ext);
    fork
      grab(60);
      begin
        repeat (20) @(negedge sys_clk);
        if (ext) errInject = 1'h1;
        else singleErr = 1'h1;
        @(negedge sys_clk);
        singleErr = 1'h0;
        repeat (4) @(negedge sys_clk);
        errInject = 1'h0;
      end
    join
    check(32'(viol(7, 6, 60)), 32'h3);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #200us;
    fail_count++;
    summarize();
  end

  initial begin
    cfg.syncDiv = 1'h1;
    repeat (20) @(negedge sys_clk);
    reset_n = 1'h1;
    repeat (3) @(negedge sys_clk);
    for (int k = 0; k < 5; k++) begin
      cfg.prbs = tpg_pkg::prbs_t'(k);
      grab(40);
      grab(120);
      check(32'(viol(ord[k], tap[k], 120)), 32'h0);
    end
    $display("test sequences finished");
    errRun(1'h0);
    errRun(1'h1);
    $display("test errors finished");
    slow = 1'h1;
    grab(100);
    check(32'(viol(7, 6, 100)), 32'h0);
    hold = 1'h1;
    repeat (20) @(negedge sys_clk);
    hold = 1'h0;
    slow = 1'h0;
    grab(60);
    check(32'(viol(7, 6, 60)), 32'h0);
    auxPresent = 1'h1;
    grab(20);
    check(32'(sum(1'h0, 12, 8)), 32'h0);
    auxPresent = 1'h0;
    clockSense = 1'h0;
    repeat (3) @(negedge sys_clk);
    check({31'h0, clockMissing}, 32'h1);
    clockSense = 1'h1;
    repeat (3) @(negedge sys_clk);
    check({31'h0, clockMissing}, 32'h0);
    $display("test flow finished");
    cfg.mode = tpg_pkg::PAT_WORDS;
    cfg.word0 = 16'h0007;
    cfg.word1 = 16'hc5a3;
    for (int s = 0; s < 2; s++) begin
      auxPresent = s[0];
      grab(40);
      grab(32);
      for (int i = 0; i < 16; i++)
        v = {v[30:0], bits[i]};
      check({31'h0, rotHit(v, s ? 32'h0007 : 32'hc5a3, 16)}, 32'h1);
      check(32'(sum(1'h1, 0, 32)), 32'h10);
    end
    wr(17'h00000, 32'h12f456a1);
    cfg.mode = tpg_pkg::PAT_USER;
    cfg.userLen = 23'h000020;
    cfg.syncPos = 23'h000005;
    auxPresent = 1'h0;
    grab(40);
    grab(32);
    for (int i = 0; i < 32; i++)
      v = {bits[i], v[31:1]};
    check({31'h0, rotHit(v, 32'h12f456a1, 32)}, 32'h1);
    check(32'(sum(1'h1, 0, 32)), 32'h1);
    cfg.mode = tpg_pkg::PAT_ZEROSUB;
    cfg.derived = tpg_pkg::DER128;
    cfg.zsRun = 23'h00007f;
    grab(168);
    check(32'(sum(1'h0, 40, 128)), 32'h1);
    $display("test words finished");
    wr(17'h00000, 32'h0);
    wr(17'h10000, 32'hffffffff);
    cfg.mode = tpg_pkg::PAT_ALT;
    cfg.altLen = 23'h000020;
    cfg.altRearSrc = 1'h1;
    auxPresent = 1'h1;
    for (int s = 0; s < 2; s++) begin
      auxIn = s[0];
      grab(80);
      grab(64);
      check(32'(sum(1'h0, 0, 64)), 32'(s * 64));
      check(32'(sum(1'h1, 0, 64)), 32'h2);
    end
    cfg.altOnce = 1'h1;
    for (int s = 0; s < 2; s++) begin
      cfg.altRearSrc = s[0];
      auxIn = 1'h0;
      grab(80);
      if (s) auxIn = 1'h1;
      else insertReq = 1'h1;
      @(negedge sys_clk);
      insertReq = 1'h0;
      grab(320);
      check(32'(sum(1'h0, 0, 320)), 32'h80);
    end
    $display("test alternation finished");
    summarize();
  end
endmodule // test_pattern_generator_tb_top
